// ===== sci_pkg.sv
// Purpose: shared constants and types for the smart card event flag block
// Assumes: 32-bit apb data, one 16-bit event register in the low half-word
// Notes:   offsets are byte addresses of aligned words
package sci_pkg;

  localparam int unsigned SCI_AW          = 12;
  localparam logic [11:0] SCI_OFF_EVENTS  = 12'h000;
  localparam logic [11:0] SCI_OFF_CTRL    = 12'h004;
  localparam logic [11:0] SCI_OFF_STATUS  = 12'h008;

  // event register bit positions
  localparam int unsigned SCI_RXRPT_FLAG_BIT = 13;
  localparam int unsigned SCI_TXRPT_FLAG_BIT = 12;
  localparam int unsigned SCI_BT_FLAG_BIT    = 10;
  localparam int unsigned SCI_WT_FLAG_BIT    = 9;
  localparam int unsigned SCI_GT_FLAG_BIT    = 8;
  localparam int unsigned SCI_RXRPT_EN_BIT   = 5;
  localparam int unsigned SCI_TXRPT_EN_BIT   = 4;
  localparam int unsigned SCI_BT_EN_BIT      = 2;
  localparam int unsigned SCI_WT_EN_BIT      = 1;
  localparam int unsigned SCI_GT_EN_BIT      = 0;
  localparam logic [15:0] SCI_EVENTS_IMPL    = 16'h3737;
  localparam logic [15:0] SCI_EVENTS_RESET   = 16'h0000;

  // control register: retry field in bits 1:0
  localparam int unsigned SCI_RETRY_LSB      = 0;
  localparam int unsigned SCI_RETRY_W        = 2;
  localparam logic [1:0]  SCI_RETRY_RESET    = 2'h0;

  // status register: rx attempts in 2:0, tx attempts in 10:8
  localparam int unsigned SCI_STAT_RX_LSB    = 0;
  localparam int unsigned SCI_STAT_TX_LSB    = 8;
  localparam int unsigned SCI_ATT_W          = 3;

  // five receptions of one character are four retransmissions
  localparam logic [2:0]  SCI_RX_RETRANSMITS = 3'h4;

  typedef struct packed {
    logic rx_rpt;
    logic tx_rpt;
    logic bt;
    logic wt;
    logic gt;
  } sci_evt_s;

  function automatic logic [15:0] sci_flags_of(input sci_evt_s e);
    logic [15:0] v;
    v = 16'h0000;
    v[SCI_RXRPT_FLAG_BIT] = e.rx_rpt;
    v[SCI_TXRPT_FLAG_BIT] = e.tx_rpt;
    v[SCI_BT_FLAG_BIT]    = e.bt;
    v[SCI_WT_FLAG_BIT]    = e.wt;
    v[SCI_GT_FLAG_BIT]    = e.gt;
    return v;
  endfunction : sci_flags_of

endpackage : sci_pkg

// ===== sci_retry_track.sv
// Purpose: count failed attempts of one character and flag the last one
// Assumes: done is a one-cycle pulse per character, err valid with it
// Notes:   a clean character restarts the count
`timescale 1ns/1ps
module sci_retry_track
  import sci_pkg::*;
#(
  parameter int unsigned CW = 3
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          done,
  input  wire logic          err,
  input  wire logic [CW-1:0] limit,
  output logic               hit_q,
  output logic [CW-1:0]      attempts_q
);

  logic          at_limit;
  logic          hit_d;
  logic [CW-1:0] attempts_d;

  assign at_limit   = (attempts_q >= limit);
  assign hit_d      = done && err && at_limit;
  assign attempts_d = !done ? attempts_q :
                      (!err || at_limit) ? '0 : CW'(attempts_q + 1'b1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hit_q      <= 1'b0;
      attempts_q <= '0;
    end else begin
      hit_q      <= hit_d;
      attempts_q <= attempts_d;
    end
  end

endmodule : sci_retry_track

// ===== sci_zero_detect.sv
// Purpose: one-cycle pulse when a down counter arrives at zero
// Assumes: counter runs on the same clock
// Notes:   a counter sitting at zero out of reset gives no pulse
`timescale 1ns/1ps
module sci_zero_detect
  import sci_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] count,
  output logic              hit_q
);

  logic nonzero_q;
  logic is_zero;

  assign is_zero = (count == '0);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nonzero_q <= 1'b0;
      hit_q     <= 1'b0;
    end else begin
      nonzero_q <= !is_zero;
      hit_q     <= is_zero && nonzero_q;
    end
  end

endmodule : sci_zero_detect

// ===== sci_top.sv
// Purpose: smart card event flags, enables and combined request, apb slave
// Assumes: detectors and time counters share clock; 50 MHz
// Notes:   one wait state on every apb access
//
// Operation
// - rx flag after five failed receptions
// - tx flag on error after last retry
// - block time flag when counter hits zero
// - waiting time flag when counter hits zero
// - guard time flag when counter hits zero
// - rx repeat request gated by its enable
// - tx repeat request gated by its enable
// - block time request gated by its enable
// - waiting time request gated by its enable
// - guard time request gated by its enable
// - flags software writable, all zero at reset
// - unimplemented bits read zero, ignore writes
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sci_top
  import sci_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [SCI_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_char_done,
  input  wire logic              rx_parity_err,
  input  wire logic              tx_char_done,
  input  wire logic              tx_line_err,
  input  wire logic [CNT_W-1:0]  block_time_count,
  input  wire logic [CNT_W-1:0]  waiting_time_count,
  input  wire logic [CNT_W-1:0]  guard_time_count,
  output logic                   sc_irq
);

  logic [15:0]            events_q;
  logic [15:0]            events_d;
  logic [SCI_RETRY_W-1:0] transmit_retry_count_q;
  logic [SCI_RETRY_W-1:0] transmit_retry_count_d;
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;
  logic                   sc_irq_q;
  logic [SCI_ATT_W-1:0]   rx_attempts;
  logic [SCI_ATT_W-1:0]   tx_attempts;
  sci_evt_s               evt;
  logic                   hit_rx;
  logic                   hit_tx;
  logic                   hit_bt;
  logic                   hit_wt;
  logic                   hit_gt;

  // ---------------- event sources
  sci_retry_track #(.CW(SCI_ATT_W)) u_rx_track (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .done       (rx_char_done),
    .err        (rx_parity_err),
    .limit      (SCI_RX_RETRANSMITS),
    .hit_q      (hit_rx),
    .attempts_q (rx_attempts)
  );

  sci_retry_track #(.CW(SCI_ATT_W)) u_tx_track (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .done       (tx_char_done),
    .err        (tx_line_err),
    .limit      ({1'b0, transmit_retry_count_q}),
    .hit_q      (hit_tx),
    .attempts_q (tx_attempts)
  );

  sci_zero_detect #(.W(CNT_W)) u_bt_zero (
    .clock   (clock),
    .sys_rst (sys_rst),
    .count   (block_time_count),
    .hit_q   (hit_bt)
  );

  sci_zero_detect #(.W(CNT_W)) u_wt_zero (
    .clock   (clock),
    .sys_rst (sys_rst),
    .count   (waiting_time_count),
    .hit_q   (hit_wt)
  );

  sci_zero_detect #(.W(CNT_W)) u_gt_zero (
    .clock   (clock),
    .sys_rst (sys_rst),
    .count   (guard_time_count),
    .hit_q   (hit_gt)
  );

  // detectors drive plain wires so the struct has a single driver
  assign evt = '{rx_rpt: hit_rx, tx_rpt: hit_tx, bt: hit_bt, wt: hit_wt, gt: hit_gt};

  // ---------------- apb decode
  logic        acc;
  logic        wr_fire;
  logic        hit_events;
  logic        hit_ctrl;
  logic        hit_status;
  logic        mapped;
  logic [15:0] hw_set;
  logic [15:0] wr_val;
  logic [31:0] rd_mux;

  assign acc        = psel && penable && !pready_q;
  // writes land only on the edge where pready is seen high
  assign wr_fire    = psel && penable && pready_q && pwrite && !pslverr_q;
  assign hit_events = (paddr == SCI_OFF_EVENTS);
  assign hit_ctrl   = (paddr == SCI_OFF_CTRL);
  assign hit_status = (paddr == SCI_OFF_STATUS);
  assign mapped     = hit_events || hit_ctrl || hit_status;

  assign hw_set   = sci_flags_of(evt);
  assign wr_val   = pwdata[15:0] & SCI_EVENTS_IMPL;
  // set wins over a software clear in the same cycle
  assign events_d = hw_set | ((wr_fire && hit_events) ? wr_val : events_q);

  assign transmit_retry_count_d = (wr_fire && hit_ctrl) ?
      pwdata[SCI_RETRY_LSB +: SCI_RETRY_W] : transmit_retry_count_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_events) begin
      rd_mux[15:0] = events_q & SCI_EVENTS_IMPL;
    end else if (hit_ctrl) begin
      rd_mux[SCI_RETRY_LSB +: SCI_RETRY_W] = transmit_retry_count_q;
    end else if (hit_status) begin
      rd_mux[SCI_STAT_RX_LSB +: SCI_ATT_W] = rx_attempts;
      rd_mux[SCI_STAT_TX_LSB +: SCI_ATT_W] = tx_attempts;
    end
  end

  // ---------------- combined request
  logic irq_d;
  assign irq_d =
      (events_q[SCI_RXRPT_FLAG_BIT] && events_q[SCI_RXRPT_EN_BIT]) ||
      (events_q[SCI_TXRPT_FLAG_BIT] && events_q[SCI_TXRPT_EN_BIT]) ||
      (events_q[SCI_BT_FLAG_BIT]    && events_q[SCI_BT_EN_BIT])    ||
      (events_q[SCI_WT_FLAG_BIT]    && events_q[SCI_WT_EN_BIT])    ||
      (events_q[SCI_GT_FLAG_BIT]    && events_q[SCI_GT_EN_BIT]);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      events_q               <= SCI_EVENTS_RESET;
      transmit_retry_count_q <= SCI_RETRY_RESET;
      sc_irq_q               <= 1'b0;
    end else begin
      events_q               <= events_d;
      transmit_retry_count_q <= transmit_retry_count_d;
      sc_irq_q               <= irq_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign sc_irq  = sc_irq_q;

  // ---------------- checks
  property p_rx_five;
    @(posedge clock) disable iff (sys_rst)
      (rx_char_done && rx_parity_err && rx_attempts == 3'h4) |=> ##1
        events_q[SCI_RXRPT_FLAG_BIT];
  endproperty
  a_rx_five: assert property (p_rx_five) else $error("rx repeat flag missed");

  property p_rx_early;
    @(posedge clock) disable iff (sys_rst)
      (rx_char_done && rx_attempts != 3'h4) |=> !evt.rx_rpt;
  endproperty
  a_rx_early: assert property (p_rx_early) else $error("rx repeat flag too early");

  property p_tx_last;
    @(posedge clock) disable iff (sys_rst)
      (tx_char_done && tx_line_err && tx_attempts == {1'b0, transmit_retry_count_q})
        |=> evt.tx_rpt;
  endproperty
  a_tx_last: assert property (p_tx_last) else $error("tx repeat event missed");

  property p_bt_zero;
    @(posedge clock) disable iff (sys_rst)
      ($past(block_time_count) != '0 && block_time_count == '0) |=> ##1
        events_q[SCI_BT_FLAG_BIT];
  endproperty
  a_bt_zero: assert property (p_bt_zero) else $error("block time flag missed");

  property p_wt_quiet;
    @(posedge clock) disable iff (sys_rst)
      (waiting_time_count != '0) |=> !evt.wt;
  endproperty
  a_wt_quiet: assert property (p_wt_quiet) else $error("waiting time flag spurious");

  property p_gt_zero;
    @(posedge clock) disable iff (sys_rst)
      ($past(guard_time_count) != '0 && guard_time_count == '0) |=> evt.gt;
  endproperty
  a_gt_zero: assert property (p_gt_zero) else $error("guard time event missed");

  property p_irq_gate;
    @(posedge clock) disable iff (sys_rst)
      ((events_q & {10'h000, events_q[13:8]}) == 16'h0000 ||
       (events_q[13:8] & events_q[5:0]) == 6'h00) |=> !sc_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enabled flag");

  property p_irq_on;
    @(posedge clock) disable iff (sys_rst)
      ((events_q[13:8] & events_q[5:0]) != 6'h00) |=> sc_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled flag gave no request");

  property p_unimpl;
    @(posedge clock) disable iff (sys_rst)
      (events_q & ~SCI_EVENTS_IMPL) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_set_wins;
    @(posedge clock) disable iff (sys_rst)
      (evt.gt && wr_fire && hit_events) |=> events_q[SCI_GT_FLAG_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

  property p_sticky;
    @(posedge clock) disable iff (sys_rst)
      (events_q[SCI_BT_FLAG_BIT] && !(wr_fire && hit_events)) |=>
        events_q[SCI_BT_FLAG_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_sw_write;
    @(posedge clock) disable iff (sys_rst)
      (wr_fire && hit_events && hw_set == 16'h0000) |=>
        events_q == ($past(pwdata[15:0]) & SCI_EVENTS_IMPL);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software write not stored");

  property p_reset_zero;
    @(posedge clock) $past(sys_rst) |-> (events_q == 16'h0000 && !sc_irq);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("nonzero after reset");

  property p_apb_answer;
    @(posedge clock) disable iff (sys_rst)
      (psel && penable && !pready) |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no ready after access");

  property p_ready_pulse;
    @(posedge clock) disable iff (sys_rst)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_tx_early;
    @(posedge clock) disable iff (sys_rst)
      (tx_char_done && tx_attempts < {1'b0, transmit_retry_count_q}) |=> !evt.tx_rpt;
  endproperty
  a_tx_early: assert property (p_tx_early) else $error("tx repeat event too early");

  property p_bt_quiet;
    @(posedge clock) disable iff (sys_rst)
      (block_time_count != '0) |=> !evt.bt;
  endproperty
  a_bt_quiet: assert property (p_bt_quiet) else $error("block time event spurious");

  property p_wt_zero;
    @(posedge clock) disable iff (sys_rst)
      ($past(waiting_time_count) != '0 && waiting_time_count == '0) |=> evt.wt;
  endproperty
  a_wt_zero: assert property (p_wt_zero) else $error("waiting time event missed");

  property p_gt_quiet;
    @(posedge clock) disable iff (sys_rst)
      (guard_time_count != '0) |=> !evt.gt;
  endproperty
  a_gt_quiet: assert property (p_gt_quiet) else $error("guard time event spurious");

  property p_rx_irq;
    @(posedge clock) disable iff (sys_rst)
      (events_q[SCI_RXRPT_FLAG_BIT] && events_q[SCI_RXRPT_EN_BIT]) |=> sc_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx repeat request missed");

  property p_tx_irq;
    @(posedge clock) disable iff (sys_rst)
      (events_q[SCI_TXRPT_FLAG_BIT] && events_q[SCI_TXRPT_EN_BIT]) |=> sc_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx repeat request missed");

endmodule : sci_top

// ===== sci_card_model.sv
// Purpose: card and line side model, detector pulses and time counters
// Assumes: one clock, all changes right after a rising edge
// Notes:   counters count down once loaded and rest at zero
`timescale 1ns/1ps
module sci_card_model
  import sci_pkg::*;
(
  input  wire logic clock,
  output logic        rx_done,
  output logic        rx_err,
  output logic        tx_done,
  output logic        tx_err,
  output logic [15:0] gt_cnt,
  output logic [15:0] wt_cnt,
  output logic [15:0] bt_cnt
);
  logic [15:0] c [3];

  assign gt_cnt = c[0];
  assign wt_cnt = c[1];
  assign bt_cnt = c[2];

  initial begin
    {rx_done, rx_err, tx_done, tx_err} = 4'h0;
    c = '{16'h0000, 16'h0000, 16'h0000};
  end

  // load only while the counter rests at zero, or the decrement races it
  always @(posedge clock)
    for (int k = 0; k < 3; k++)
      if (c[k] != 16'h0000) c[k] <= c[k] - 16'h0001;

  task automatic load(input int i, input logic [15:0] v);
    @(posedge clock);
    c[i] <= v;
  endtask : load

  task automatic send(input logic t, input logic e);
    @(posedge clock);
    if (t) begin
      tx_done <= 1'b1;
      tx_err  <= e;
    end else begin
      rx_done <= 1'b1;
      rx_err  <= e;
    end
    @(posedge clock);
    {rx_done, tx_done} <= 2'h0;
    // both error lines are inverted, not held, once the pulse is gone
    rx_err <= ~rx_err;
    tx_err <= ~tx_err;
  endtask : send
endmodule : sci_card_model

// ===== sci_top_tb_top.sv
// Purpose: self-checking bench for the smart card event flag block
// Assumes: apb answers with one wait state, bench waits for pready anyway
// Notes:   a guard expiry is lined up with a clear to show the set wins
`timescale 1ns/1ps
module sci_top_tb_top
  import sci_pkg::*;
;
  logic        clock, sys_rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, e, sc_irq;
  logic        rxd, rxe, txd, txe;
  logic [15:0] gtc, wtc, btc;
  int          err_count, cmp_count;

  sci_top i_sci_top (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char_done(rxd), .rx_parity_err(rxe), .tx_char_done(txd),
    .tx_line_err(txe), .block_time_count(btc), .waiting_time_count(wtc),
    .guard_time_count(gtc), .sc_irq(sc_irq));

  sci_card_model i_sci_card_model (.clock(clock), .rx_done(rxd),
    .rx_err(rxe), .tx_done(txd), .tx_err(txe), .gt_cnt(gtc),
    .wt_cnt(wtc), .bt_cnt(btc));

  always #10 clock = ~clock;

  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // entered right after a rising edge; released only after pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t no pready", $time);
      end_sim();
    end
    // one idle edge, so a following call never reassigns psel in this time step
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask : rd

  task automatic irq(input logic exp);
    // look one edge later, once the registered request has settled
    @(posedge clock);
    chk({31'h0, sc_irq}, {31'h0, exp});
  endtask : irq

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(SCI_OFF_EVENTS, 32'h0);
    rd(SCI_OFF_CTRL, 32'h0);
    irq(1'b0);
    apb(1'b1, SCI_OFF_EVENTS, 32'hffff_ffff);
    rd(SCI_OFF_EVENTS, 32'h0000_3737);
    irq(1'b1);
    apb(1'b1, SCI_OFF_EVENTS, 32'h0);
    rd(SCI_OFF_EVENTS, 32'h0);
    irq(1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // time counters: index 0 guard, 1 waiting, 2 block; masked then enabled
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 2; m++) begin
        apb(1'b1, SCI_OFF_EVENTS, 32'(m) << i);
        i_sci_card_model.load(i, 16'h000c);
        rd(SCI_OFF_EVENTS, 32'(m) << i);
        repeat (16) @(posedge clock);
        rd(SCI_OFF_EVENTS, (32'h1 << (8 + i)) | (32'(m) << i));
        rd(SCI_OFF_EVENTS, (32'h1 << (8 + i)) | (32'(m) << i));
        irq(m[0]);
        apb(1'b1, SCI_OFF_EVENTS, 32'h0);
      end
    end
    // guard expiry lands in the very cycle of a clear: the set must win
    i_sci_card_model.load(0, 16'h0001);
    apb(1'b1, SCI_OFF_EVENTS, 32'h0);
    rd(SCI_OFF_EVENTS, 32'h1 << SCI_GT_FLAG_BIT);
    apb(1'b1, SCI_OFF_EVENTS, 32'h0);
    // a clean character in between restarts the count of failures
    apb(1'b1, SCI_OFF_EVENTS, 32'h0000_0020);
    repeat (3) i_sci_card_model.send(1'b0, 1'b1);
    i_sci_card_model.send(1'b0, 1'b0);
    repeat (4) i_sci_card_model.send(1'b0, 1'b1);
    rd(SCI_OFF_EVENTS, 32'h0000_0020);
    rd(SCI_OFF_STATUS, 32'(SCI_RX_RETRANSMITS) << SCI_STAT_RX_LSB);
    irq(1'b0);
    i_sci_card_model.send(1'b0, 1'b1);
    repeat (4) @(posedge clock);
    rd(SCI_OFF_EVENTS, 32'h0000_2020);
    irq(1'b1);
    apb(1'b1, SCI_OFF_EVENTS, 32'h0);
    // every retry count: error on attempt r+1 is the first to flag
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, SCI_OFF_CTRL, 32'(k));
      rd(SCI_OFF_CTRL, 32'(k));
      apb(1'b1, SCI_OFF_EVENTS, 32'h0000_0010);
      i_sci_card_model.send(1'b1, 1'b0);
      repeat (k) i_sci_card_model.send(1'b1, 1'b1);
      rd(SCI_OFF_EVENTS, 32'h0000_0010);
      rd(SCI_OFF_STATUS, 32'(k) << SCI_STAT_TX_LSB);
      i_sci_card_model.send(1'b1, 1'b1);
      repeat (4) @(posedge clock);
      rd(SCI_OFF_EVENTS, 32'h0000_1010);
      irq(1'b1);
      apb(1'b1, SCI_OFF_EVENTS, 32'h0);
      irq(1'b0);
    end
    end_sim();
  end
endmodule : sci_top_tb_top
